// [logic/smcs_pkg.sv]
// constants, enumerations and carriers shared by the spi memory command slave
// assumes a single core clock domain; spi pins are sampled, never used as clocks
package smcs_pkg;

	localparam logic [7:0] CMD_SET_WE = 8'h06;
	localparam logic [7:0] CMD_CLR_WE = 8'h04;
	localparam logic [7:0] CMD_STATUS_RD = 8'h05;
	localparam logic [7:0] CMD_STATUS_WR = 8'h01;
	localparam logic [7:0] CMD_MEM_RD = 8'h03;
	localparam logic [7:0] CMD_MEM_WR = 8'h02;
	localparam logic [7:0] CMD_COMP_RD = 8'h13;
	localparam logic [7:0] CMD_COMP_WR = 8'h12;

	localparam int MEM_AW = 15;
	localparam int COMP_AW = 5;
	localparam int DW = 8;

	localparam logic [14:0] MEM_FIRST = 15'h0000;
	localparam logic [14:0] MEM_LAST = 15'h7fff;
	localparam logic [14:0] ADDR_STEP = 15'h0001;
	localparam logic [4:0] COMP_FIRST = 5'h00;
	localparam logic [4:0] COMP_LAST = 5'h1d;
	localparam logic [14:0] PROT_QTR_BASE = 15'h6000;
	localparam logic [14:0] PROT_HALF_BASE = 15'h4000;

	localparam logic [1:0] BP_NONE = 2'h0;
	localparam logic [1:0] BP_QTR = 2'h1;
	localparam logic [1:0] BP_HALF = 2'h2;
	localparam logic [1:0] BP_ALL = 2'h3;

	// fixed status pattern: bit 6 reads one, bits 0, 4, 5, 7 read zero
	localparam logic [7:0] STATUS_FIXED = 8'h40;
	localparam int STATUS_WEL_BIT = 1;
	localparam int STATUS_BP_LSB = 2;

	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_STEP = 3'h1;

	localparam logic [1:0] BUF_EMPTY = 2'h0;
	localparam logic [1:0] BUF_FULL = 2'h2;
	localparam logic [1:0] BUF_STEP = 2'h1;

	typedef enum logic [2:0] {
		PH_OPCODE = 3'h0,
		PH_ADDR_HI = 3'h1,
		PH_ADDR_LO = 3'h3,
		PH_DATA = 3'h2,
		PH_IGNORE = 3'h6
	} smcs_phase_t;

	typedef struct packed {
		logic sck;
		logic cs_n;
		logic si;
	} smcs_pins_t;

	localparam smcs_pins_t PINS_IDLE = '{sck: 1'h0, cs_n: 1'h1, si: 1'h0};

	typedef struct packed {
		logic comp;
		logic [14:0] addr;
		logic [7:0] data;
	} smcs_wr_t;

endpackage

// [logic/smcs_byte_mem.sv]
// byte-wide storage with one write port and one registered read port
// assumes writes and reads are issued on core_clk; contents are not reset
`timescale 1ns/1ps
module smcs_byte_mem #(
	parameter int AW = 5
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic re,
	input wire logic [AW-1:0] raddr,
	output logic [7:0] rdata
);

	logic [7:0] store [2**AW];

	// written immediately, no page staging
	always_ff @(posedge core_clk) begin
		if (ce && we) begin
			store[waddr] <= wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (ce && re) begin
			rdata <= store[raddr];
		end
	end

endmodule

// [logic/smcs_spi_slave.sv]
// spi slave command logic: opcode decode, write enable latch, status register,
// memory and companion byte streams with a two-entry write buffer
// assumes sck, cs_n and si arrive asynchronously and sck is at least 8x slower than core_clk
`timescale 1ns/1ps

// Overview of operation
// - set-write-enable opcode sets the write enable latch
// - clear-write-enable opcode clears the latch, blocking all writes
// - latch clears at chip select rise ending clear, status, companion or memory writes
// - latch is zero after reset, so writes start disabled
// - status write byte never changes the latch bit
// - status bits 0, 4, 5, 7 read zero, bit 6 reads one, unwritable
// - status bits 2 and 3 are block-protect bits kept in nonvolatile storage
// - protect code selects none, upper quarter, upper half or whole array
// - status-read opcode returns the status byte, repeated on each further byte until deselect
// - status write updates protect bits only with the latch set
// - companion read returns bytes sequentially, address wrapping 1dh to 00h
// - companion write programs bytes sequentially, wraps, needs the latch
// - memory address is two bytes, top bit ignored, low 15 bits used
// - sequential address increments per byte, rolling 7fffh to 0000h
// - burst write reaching protected block stops incrementing, drops later bytes
// - each written byte commits after its eighth bit; partial bytes dropped
// - memory read drives data on following clocks, ignoring serial input
// - chip select rise ends reads and releases the serial output
// - data moves most significant bit first
// - unknown opcode: ignore input until next selection, output released
// - sample input on sck rise, change output on sck fall
// - one opcode per selection; first byte after selection is the opcode
module smcs_spi_slave (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic [1:0] nv_bp,
	output logic so,
	output logic so_oe,
	output logic [1:0] bp
);

	function automatic logic is_read(input logic [7:0] cmd);
		return cmd == smcs_pkg::CMD_MEM_RD || cmd == smcs_pkg::CMD_COMP_RD || cmd == smcs_pkg::CMD_STATUS_RD;
	endfunction

	function automatic logic is_comp(input logic [7:0] cmd);
		return cmd == smcs_pkg::CMD_COMP_RD || cmd == smcs_pkg::CMD_COMP_WR;
	endfunction

	function automatic logic ends_write(input logic [7:0] cmd);
		return cmd == smcs_pkg::CMD_CLR_WE || cmd == smcs_pkg::CMD_STATUS_WR ||
			cmd == smcs_pkg::CMD_COMP_WR || cmd == smcs_pkg::CMD_MEM_WR;
	endfunction

	function automatic logic [14:0] next_addr(input logic comp, input logic [14:0] addr);
		logic [14:0] nxt;
		nxt = addr + smcs_pkg::ADDR_STEP;
		if (comp) begin
			nxt = (addr[4:0] >= smcs_pkg::COMP_LAST) ? {10'h000, smcs_pkg::COMP_FIRST} : nxt;
		end else if (addr == smcs_pkg::MEM_LAST) begin
			nxt = smcs_pkg::MEM_FIRST;
		end
		return nxt;
	endfunction

	function automatic logic is_protected(input logic [1:0] code, input logic [14:0] addr);
		logic hit;
		unique case (code)
			smcs_pkg::BP_NONE: hit = 1'h0;
			smcs_pkg::BP_QTR: hit = addr >= smcs_pkg::PROT_QTR_BASE;
			smcs_pkg::BP_HALF: hit = addr >= smcs_pkg::PROT_HALF_BASE;
			smcs_pkg::BP_ALL: hit = 1'h1;
		endcase
		return hit;
	endfunction

	// pin synchroniser: meta_r is read only by sync_r
	smcs_pkg::smcs_pins_t pins_in;
	smcs_pkg::smcs_pins_t meta_r;
	smcs_pkg::smcs_pins_t sync_r;
	smcs_pkg::smcs_pins_t last_r;

	assign pins_in = '{sck: sck, cs_n: cs_n, si: si};

	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_r <= smcs_pkg::PINS_IDLE;
			sync_r <= smcs_pkg::PINS_IDLE;
			last_r <= smcs_pkg::PINS_IDLE;
		end else if (ce) begin
			meta_r <= pins_in;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	logic selected;
	logic cs_fall;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;

	assign selected = !sync_r.cs_n;
	assign cs_fall = selected && last_r.cs_n;
	assign cs_rise = !selected && !last_r.cs_n;
	// only edges inside a selection count; a mode 3 idle-high clock gives a harmless first fall
	assign sck_rise = selected && !cs_fall && sync_r.sck && !last_r.sck;
	assign sck_fall = selected && !cs_fall && !sync_r.sck && last_r.sck;

	// two-entry write buffer between the shifter and the storage ports
	smcs_pkg::smcs_wr_t buf_r [2];
	smcs_pkg::smcs_wr_t buf_nxt [2];
	logic [1:0] buf_cnt_r;
	logic [1:0] buf_cnt_nxt;
	logic in_valid;
	logic in_ready;
	smcs_pkg::smcs_wr_t in_data;
	logic out_valid;
	logic out_ready;
	logic rd_go_r;

	assign in_ready = buf_cnt_r != smcs_pkg::BUF_FULL;
	assign out_valid = buf_cnt_r != smcs_pkg::BUF_EMPTY;
	// the shared address path stalls draining for the cycle a read is issued
	assign out_ready = !rd_go_r;

	always_comb begin
		logic push;
		logic pop;
		logic [1:0] slot;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		buf_nxt = buf_r;
		buf_cnt_nxt = buf_cnt_r;
		slot = buf_cnt_r;
		if (pop) begin
			buf_nxt[0] = buf_r[1];
			slot = buf_cnt_r - smcs_pkg::BUF_STEP;
		end
		if (push) begin
			buf_nxt[slot[0]] = in_data;
		end
		if (push && !pop) begin
			buf_cnt_nxt = buf_cnt_r + smcs_pkg::BUF_STEP;
		end else if (pop && !push) begin
			buf_cnt_nxt = buf_cnt_r - smcs_pkg::BUF_STEP;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			buf_cnt_r <= smcs_pkg::BUF_EMPTY;
			buf_r[0] <= '0;
			buf_r[1] <= '0;
		end else if (ce) begin
			buf_cnt_r <= buf_cnt_nxt;
			buf_r <= buf_nxt;
		end
	end

	// command engine state
	smcs_pkg::smcs_phase_t phase_r;
	smcs_pkg::smcs_phase_t phase_nxt;
	logic [7:0] cmd_r;
	logic [7:0] cmd_nxt;
	logic cmd_ok_r;
	logic cmd_ok_nxt;
	logic [2:0] bit_cnt_r;
	logic [2:0] bit_cnt_nxt;
	logic [6:0] rx_r;
	logic [6:0] rx_nxt;
	logic [14:0] addr_r;
	logic [14:0] addr_nxt;
	logic [7:0] tx_r;
	logic [7:0] tx_nxt;
	logic so_r;
	logic so_nxt;
	logic so_oe_r;
	logic so_oe_nxt;
	logic wel_r;
	logic wel_nxt;
	logic [1:0] bp_r;
	logic [1:0] bp_nxt;
	logic stop_r;
	logic stop_nxt;
	logic rd_go_nxt;
	logic [7:0] mem_rdata;
	logic [7:0] comp_rdata;

	always_comb begin
		logic [7:0] rx_byte;
		logic [7:0] status;
		logic [7:0] src;
		rx_byte = {rx_r, sync_r.si};
		status = smcs_pkg::STATUS_FIXED;
		status[smcs_pkg::STATUS_WEL_BIT] = wel_r;
		status[smcs_pkg::STATUS_BP_LSB +: 2] = bp_r;
		src = (cmd_r == smcs_pkg::CMD_STATUS_RD) ? status : (is_comp(cmd_r) ? comp_rdata : mem_rdata);
		phase_nxt = phase_r;
		cmd_nxt = cmd_r;
		cmd_ok_nxt = cmd_ok_r;
		bit_cnt_nxt = bit_cnt_r;
		rx_nxt = rx_r;
		addr_nxt = addr_r;
		tx_nxt = tx_r;
		so_nxt = so_r;
		so_oe_nxt = so_oe_r;
		wel_nxt = wel_r;
		bp_nxt = bp_r;
		stop_nxt = stop_r;
		rd_go_nxt = 1'h0;
		in_valid = 1'h0;
		in_data = '{comp: is_comp(cmd_r), addr: addr_r, data: rx_byte};
		if (rd_go_r) begin
			addr_nxt = next_addr(is_comp(cmd_r), addr_r);
		end
		if (cs_fall) begin
			phase_nxt = smcs_pkg::PH_OPCODE;
			bit_cnt_nxt = smcs_pkg::BIT_FIRST;
			cmd_ok_nxt = 1'h0;
			stop_nxt = 1'h0;
			so_oe_nxt = 1'h0;
		end else if (cs_rise) begin
			if (cmd_ok_r && ends_write(cmd_r)) begin
				wel_nxt = 1'h0;
			end
			phase_nxt = smcs_pkg::PH_IGNORE;
			cmd_ok_nxt = 1'h0;
			so_oe_nxt = 1'h0;
		end else if (sck_rise) begin
			rx_nxt = rx_byte[6:0];
			bit_cnt_nxt = bit_cnt_r + smcs_pkg::BIT_STEP;
			// a byte cut short by chip select never reaches this point
			if (bit_cnt_r == smcs_pkg::BIT_LAST) begin
				unique case (phase_r)
					smcs_pkg::PH_OPCODE: begin
						cmd_nxt = rx_byte;
						cmd_ok_nxt = 1'h1;
						phase_nxt = smcs_pkg::PH_IGNORE;
						unique case (rx_byte)
							smcs_pkg::CMD_SET_WE: wel_nxt = 1'h1;
							smcs_pkg::CMD_CLR_WE: wel_nxt = 1'h0;
							smcs_pkg::CMD_STATUS_RD, smcs_pkg::CMD_STATUS_WR: phase_nxt = smcs_pkg::PH_DATA;
							smcs_pkg::CMD_MEM_RD, smcs_pkg::CMD_MEM_WR: phase_nxt = smcs_pkg::PH_ADDR_HI;
							smcs_pkg::CMD_COMP_RD, smcs_pkg::CMD_COMP_WR: begin
								phase_nxt = smcs_pkg::PH_ADDR_LO;
								addr_nxt = smcs_pkg::MEM_FIRST;
							end
							default: cmd_ok_nxt = 1'h0;
						endcase
					end
					smcs_pkg::PH_ADDR_HI: begin
						addr_nxt = {rx_byte[6:0], addr_r[7:0]};
						phase_nxt = smcs_pkg::PH_ADDR_LO;
					end
					smcs_pkg::PH_ADDR_LO: begin
						addr_nxt = is_comp(cmd_r) ? {10'h000, rx_byte[4:0]} : {addr_r[14:8], rx_byte};
						phase_nxt = smcs_pkg::PH_DATA;
						rd_go_nxt = is_read(cmd_r);
					end
					smcs_pkg::PH_DATA: begin
						if (is_read(cmd_r)) begin
							rd_go_nxt = 1'h1;
						end else if (cmd_r == smcs_pkg::CMD_STATUS_WR) begin
							if (wel_r) begin
								bp_nxt = rx_byte[smcs_pkg::STATUS_BP_LSB +: 2];
							end
							phase_nxt = smcs_pkg::PH_IGNORE;
						end else if (wel_r && !stop_r) begin
							if (!is_comp(cmd_r) && is_protected(bp_r, addr_r)) begin
								stop_nxt = 1'h1;
							end else begin
								in_valid = 1'h1;
								addr_nxt = next_addr(is_comp(cmd_r), addr_r);
							end
						end
					end
					smcs_pkg::PH_IGNORE: begin
					end
				endcase
			end
		end else if (sck_fall && phase_r == smcs_pkg::PH_DATA && is_read(cmd_r)) begin
			so_oe_nxt = 1'h1;
			if (bit_cnt_r == smcs_pkg::BIT_FIRST) begin
				so_nxt = src[7];
				tx_nxt = {src[6:0], 1'h0};
			end else begin
				so_nxt = tx_r[7];
				tx_nxt = {tx_r[6:0], 1'h0};
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			phase_r <= smcs_pkg::PH_IGNORE;
			cmd_r <= 8'h00;
			cmd_ok_r <= 1'h0;
			bit_cnt_r <= smcs_pkg::BIT_FIRST;
			rx_r <= 7'h00;
			addr_r <= smcs_pkg::MEM_FIRST;
			tx_r <= 8'h00;
			so_r <= 1'h0;
			so_oe_r <= 1'h0;
			wel_r <= 1'h0;
			bp_r <= nv_bp;
			stop_r <= 1'h0;
			rd_go_r <= 1'h0;
		end else if (ce) begin
			phase_r <= phase_nxt;
			cmd_r <= cmd_nxt;
			cmd_ok_r <= cmd_ok_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			rx_r <= rx_nxt;
			addr_r <= addr_nxt;
			tx_r <= tx_nxt;
			so_r <= so_nxt;
			so_oe_r <= so_oe_nxt;
			wel_r <= wel_nxt;
			bp_r <= bp_nxt;
			stop_r <= stop_nxt;
			rd_go_r <= rd_go_nxt;
		end
	end

	assign so = so_r;
	assign so_oe = so_oe_r;
	assign bp = bp_r;

	smcs_byte_mem #(
		.AW(smcs_pkg::MEM_AW)
	) u_array (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.we(out_valid && out_ready && !buf_r[0].comp),
		.waddr(buf_r[0].addr),
		.wdata(buf_r[0].data),
		.re(rd_go_r),
		.raddr(addr_r),
		.rdata(mem_rdata)
	);

	smcs_byte_mem #(
		.AW(smcs_pkg::COMP_AW)
	) u_companion (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.we(out_valid && out_ready && buf_r[0].comp),
		.waddr(buf_r[0].addr[4:0]),
		.wdata(buf_r[0].data),
		.re(rd_go_r),
		.raddr(addr_r[4:0]),
		.rdata(comp_rdata)
	);

endmodule

// [bench/smcs_spi_slave_sva.sv]
// assertions on the spi command slave's pins and block-protect output
// assumes ce stays high while the link is in use
`timescale 1ns/1ps
module smcs_spi_slave_sva (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic [1:0] nv_bp,
	input wire logic so,
	input wire logic so_oe,
	input wire logic [1:0] bp
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	sequence s_cs_idle;
		cs_n [*6];
	endsequence
	sequence s_oe_start;
		!so_oe ##1 so_oe;
	endsequence
	chk_reset_quiet: assert property (disable iff (1'b0) ce && rst |=> !so_oe && !so)
		else $error("serial output active after reset");
	chk_reset_bp: assert property (disable iff (1'b0) ce && rst |=> bp == $past(nv_bp))
		else $error("protect bits not loaded at reset");
	chk_idle_released: assert property (s_cs_idle |-> !so_oe)
		else $error("serial output driven while deselected");
	chk_release_bound: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
		else $error("serial output not released after deselect");
	chk_so_on_fall: assert property (so_oe && $past(so_oe) && $changed(so) |->
		!$past(sck, 2) && !$past(sck, 3))
		else $error("serial output changed outside a clock fall");
	chk_oe_on_fall: assert property (s_oe_start |-> !$past(sck, 2) && !$past(cs_n, 4))
		else $error("output enabled outside a selected clock fall");
	chk_oe_hold: assert property ($rose(so_oe) |-> so_oe [*4])
		else $error("output enable dropped too early");
	chk_bp_in_select: assert property (!$past(rst) && $changed(bp) |-> !$past(cs_n, 4))
		else $error("protect bits changed without a selection");
endmodule
bind smcs_spi_slave smcs_spi_slave_sva u_sva (.core_clk(core_clk), .rst(rst), .ce(ce), .sck(sck),
	.cs_n(cs_n), .si(si), .nv_bp(nv_bp), .so(so), .so_oe(so_oe), .bp(bp));

// [bench/smcs_spi_master.sv]
// spi bus master model, mode 0 or 3, half period counted in core clocks
// assumes the bench calls its tasks; pins change only at core clock falls
`timescale 1ns/1ps
module smcs_spi_master (
	input wire logic core_clk,
	input wire logic so,
	output logic sck,
	output logic cs_n,
	output logic si
);
	int half = 4;
	logic mode3 = 1'b0;
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	task automatic wait_half();
		repeat (half) @(negedge core_clk);
	endtask
	// every selection starts afresh with an opcode
	task automatic start();
		@(negedge core_clk);
		sck = mode3;
		wait_half();
		cs_n = 1'b0;
		wait_half();
	endtask
	// msb first out, answer taken at the rise
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck = 1'b0;
			si = tx[i];
			wait_half();
			sck = 1'b1;
			rx[i] = so;
			wait_half();
		end
	endtask
	task automatic stop();
		sck = mode3;
		wait_half();
		cs_n = 1'b1;
		// released data line flips so a stale level is never trusted
		si = ~si;
		repeat (2) wait_half();
	endtask
endmodule

// [bench/smcs_spi_slave_tb.sv]
// self-checking bench for the spi command slave with a master model
// assumes the block's memory starts unknown, so every read location is written first
`timescale 1ns/1ps
module smcs_spi_slave_tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] nv_bp = 2'h0;
	logic oe_seen = 1'b0;
	logic sck;
	logic cs_n;
	logic si;
	logic so;
	logic so_oe;
	logic [1:0] bp;
	wire so_line;
	int bad_count = 0;
	int compares = 0;
	logic [7:0] rx_q [$];
	assign so_line = so_oe ? so : 1'bz;
	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (so_oe === 1'b1) oe_seen <= 1'b1;
	smcs_spi_slave u_dut (.core_clk(core_clk), .rst(rst), .ce(1'b1), .sck(sck), .cs_n(cs_n), .si(si),
		.nv_bp(nv_bp), .so(so), .so_oe(so_oe), .bp(bp));
	smcs_spi_master u_master (.core_clk(core_clk), .so(so_line), .sck(sck), .cs_n(cs_n), .si(si));
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic run(input logic [7:0] q [$]);
		logic [7:0] r;
		rx_q = {};
		u_master.start();
		foreach (q[i]) begin
			u_master.xfer(q[i], r);
			rx_q.push_back(r);
		end
		u_master.stop();
	endtask
	task automatic status(input logic [7:0] exp);
		run({8'h05, 8'h00});
		check("status", exp, rx_q[1]);
	endtask
	task automatic do_reset(input logic [1:0] nv);
		@(negedge core_clk);
		nv_bp = nv;
		rst = 1'b1;
		repeat (10) @(negedge core_clk);
		rst = 1'b0;
		repeat (4) @(negedge core_clk);
		check("bp", {6'h00, nv}, {6'h00, bp});
	endtask
	task automatic t_latch();
		status(8'h40);
		run({8'h06});
		status(8'h42);
		run({8'h04});
		status(8'h40);
		$display("test latch done");
	endtask
	task automatic t_status();
		run({8'h06});
		run({8'h01, 8'hff});
		status(8'h4c);
		check("bp", 8'h03, {6'h00, bp});
		run({8'h01, 8'h00});
		status(8'h4c);
		run({8'h06});
		run({8'h01, 8'h00});
		status(8'h40);
		$display("test status done");
	endtask
	task automatic t_mem();
		run({8'h06});
		run({8'h02, 8'hff, 8'hff, 8'h5a, 8'hc3});
		run({8'h06});
		run({8'h02, 8'h5f, 8'hfe, 8'h01, 8'h02, 8'h03});
		run({8'h06});
		run({8'h01, 8'h04});
		run({8'h06});
		run({8'h02, 8'hdf, 8'hfe, 8'hf1, 8'hf2, 8'hf3, 8'hf4});
		run({8'h02, 8'h00, 8'h00, 8'h99});
		run({8'h03, 8'h5f, 8'hfe, 8'h00, 8'h00, 8'h00});
		check("mem", 8'hf1, rx_q[3]);
		check("mem", 8'hf2, rx_q[4]);
		check("mem", 8'h03, rx_q[5]);
		run({8'h03, 8'h7f, 8'hff, 8'ha5, 8'h3c});
		check("mem", 8'h5a, rx_q[3]);
		check("mem", 8'hc3, rx_q[4]);
		$display("test memory done");
	endtask
	task automatic t_comp();
		run({8'h06});
		run({8'h12, 8'h1d, 8'h77, 8'h88});
		run({8'h12, 8'h00, 8'h55});
		run({8'h13, 8'h1d, 8'h00, 8'h00});
		check("comp", 8'h77, rx_q[2]);
		check("comp", 8'h88, rx_q[3]);
		$display("test companion done");
	endtask
	task automatic t_odd();
		oe_seen = 1'b0;
		run({8'hff, 8'h13, 8'h1d, 8'h00});
		check("oe", 8'h00, {7'h00, oe_seen});
		u_master.mode3 = 1'b1;
		u_master.half = 8;
		status(8'h44);
		u_master.mode3 = 1'b0;
		u_master.half = 4;
		$display("test odd opcode and mode 3 done");
	endtask
	task automatic t_nv();
		do_reset(2'h3);
		status(8'h4c);
		run({8'h06});
		run({8'h02, 8'h00, 8'h00, 8'h11});
		run({8'h03, 8'h00, 8'h00, 8'h00});
		check("mem", 8'hc3, rx_q[3]);
		$display("test stored protect done");
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge core_clk);
		bad_count++;
		conclude();
	end
	initial begin
		do_reset(2'h0);
		t_latch();
		t_status();
		t_mem();
		t_comp();
		t_odd();
		t_nv();
		conclude();
	end
endmodule
